// file: hw/priority_pin_crossbar.sv
// Purpose: priority crossbar mapping peripherals onto 16 port pins
// Assumes: pins sampled through two flops; config from same clock
// Notes: pin outputs registered, so config acts on the next edge
`timescale 1ns/1ps
module priority_pin_crossbar
   import xbar_pkg::*;
#(
   parameter bit UART_ALT = 1'b0
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // configuration
   input wire logic [7:0] i_periph_select_lo,
   input wire logic [7:0] i_periph_select_hi,
   input wire logic i_xbar_enable,
   input wire logic i_pullup_disable,
   input wire logic [7:0] i_port0_skip_bits,
   input wire logic [7:0] i_port1_skip_bits,
   input wire logic [15:0] i_input_mode_bits,
   input wire logic [15:0] i_output_mode_bits,
   input wire logic [1:0] i_slave_select_mode,
   // port latch written by software
   input wire logic [15:0] i_port_latch,
   // peripheral outputs by function slot
   input wire logic [15:0] i_func_out,
   // pins
   input wire logic [15:0] i_pin,
   output logic [15:0] o_pin,
   output logic [15:0] o_pin_oe,
   output logic [15:0] o_pullup_en,
   output logic [15:0] o_rx_en,
   // read back and peripheral inputs
   output logic [15:0] o_port_read,
   output logic [15:0] o_func_in,
   // allocation status
   output logic [15:0] o_pin_assigned
);
   logic [15:0] pin_s;
   logic [15:0] want;
   logic [15:0] skip;
   logic [4:0] map [NPINS];
   logic [15:0] asg;
   logic [15:0] pin_nxt, oe_nxt, pu_nxt, rx_nxt, rd_nxt, fin_nxt;
   logic [15:0] pin_r, oe_r, pu_r, rx_r, rd_r, fin_r, asg_r;
   logic [3:0] tx_pin, rx_pin;

   pin_sync #(.W(16)) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async(i_pin),
      .o_sync(pin_s)
   );

   assign tx_pin = UART_ALT ? UART_TX_PIN_B : UART_TX_PIN_A;
   assign rx_pin = UART_ALT ? UART_RX_PIN_B : UART_RX_PIN_A;
   assign skip = {i_port1_skip_bits, i_port0_skip_bits};

   // requested functions, in rank order
   always_comb begin
      want = '0;
      want[F_TX] = i_periph_select_lo[SEL_UART];
      want[F_RX] = i_periph_select_lo[SEL_UART];
      want[F_SCK] = i_periph_select_lo[SEL_SPI];
      want[F_MISO] = i_periph_select_lo[SEL_SPI];
      want[F_MOSI] = i_periph_select_lo[SEL_SPI];
      want[F_NSS] = i_periph_select_lo[SEL_SPI] &&
         (i_slave_select_mode != NSS_3WIRE);
      // two-wire bus pair shares the lin slot pair
      want[F_LIN_TX] = i_periph_select_lo[SEL_LIN];
      want[F_LIN_RX] = i_periph_select_lo[SEL_LIN];
      want[F_SYSCK] = i_periph_select_lo[SEL_SYSCK];
      want[F_CMP] = i_periph_select_lo[SEL_CMP];
      want[F_CMPA] = i_periph_select_lo[SEL_CMPA];
      want[F_CEX0] = |i_periph_select_hi[SEL_PCA_LO +: 2];
      want[F_CEX1] = i_periph_select_hi[SEL_PCA_LO + 1];
      want[F_CEX2] = &i_periph_select_hi[SEL_PCA_LO +: 2];
      want[F_ECI] = i_periph_select_hi[SEL_ECI];
      want[F_T0] = i_periph_select_hi[SEL_T0] ||
         i_periph_select_hi[SEL_T1];
   end

   // priority allocation; uart fixed, the rest fill lowest free pins
   always_comb begin
      logic [15:0] used;
      int p;
      used = '0;
      p = 0;
      for (int i = 0; i < NPINS; i++) begin
         map[i] = NOFUNC;
      end
      if (want[F_TX]) begin
         map[tx_pin] = {1'b0, F_TX};
         map[rx_pin] = {1'b0, F_RX};
         used[tx_pin] = 1'b1;
         used[rx_pin] = 1'b1;
      end
      for (int f = 2; f < NFUNC; f++) begin
         if (want[f]) begin
            p = NPINS;
            for (int q = NPINS - 1; q >= 0; q--) begin
               if (!used[q] && !skip[q]) begin
                  p = q;
               end
            end
            if (p < NPINS) begin
               map[p] = 5'(f);
               used[p] = 1'b1;
            end
         end
      end
      for (int i = 0; i < NPINS; i++) begin
         asg[i] = i_xbar_enable && (map[i] != NOFUNC);
      end
   end

   // pin cell behaviour
   always_comb begin
      logic drv;
      logic en;
      drv = 1'b0;
      en = 1'b0;
      fin_nxt = '0;
      for (int i = 0; i < NPINS; i++) begin
         // unassigned pins are plain port io
         drv = asg[i] ? i_func_out[map[i][3:0]] : i_port_latch[i];
         en = i_xbar_enable && i_input_mode_bits[i];
         pin_nxt[i] = drv && i_output_mode_bits[i];
         // push-pull drives both levels; open-drain only pulls low
         oe_nxt[i] = en && (i_output_mode_bits[i] || !drv);
         pu_nxt[i] = i_input_mode_bits[i] && !i_output_mode_bits[i] &&
            !i_pullup_disable && !(en && !drv);
         rx_nxt[i] = i_input_mode_bits[i];
         // analog pins read 0; digital read the pin itself
         rd_nxt[i] = i_input_mode_bits[i] && pin_s[i];
         if (asg[i] && i_input_mode_bits[i]) begin
            fin_nxt[map[i][3:0]] = pin_s[i];
         end
      end
   end

   // registered outputs; reset leaves all pins digital inputs
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_r <= '0;
         oe_r <= '0;
         pu_r <= '1;
         rx_r <= INMODE_RST;
         rd_r <= '0;
         fin_r <= '0;
         asg_r <= '0;
      end else begin
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
         pu_r <= pu_nxt;
         rx_r <= rx_nxt;
         rd_r <= rd_nxt;
         fin_r <= fin_nxt;
         asg_r <= asg;
      end
   end

   assign o_pin = pin_r;
   assign o_pin_oe = oe_r;
   assign o_pullup_en = pu_r;
   assign o_rx_en = rx_r;
   assign o_port_read = rd_r;
   assign o_func_in = fin_r;
   assign o_pin_assigned = asg_r;

   // checks
   a_drv_off_dis: assert property (@(posedge i_mclk) disable iff (i_rst)
      !$past(i_xbar_enable) |-> o_pin_oe == 16'h0000)
      else $error("driver on while crossbar disabled");
   a_plain_when_dis: assert property (@(posedge i_mclk) disable iff (i_rst)
      !$past(i_xbar_enable) |-> o_pin_assigned == 16'h0000)
      else $error("pin assigned while crossbar disabled");
   a_skip_excl: assert property (@(posedge i_mclk) disable iff (i_rst)
      ($past(skip) & ~(16'h0001 << tx_pin) & ~(16'h0001 << rx_pin)
       & o_pin_assigned) == 16'h0000 || $past(skip) != skip)
      else $error("skipped pin was assigned");
   a_analog_off: assert property (@(posedge i_mclk) disable iff (i_rst)
      ($past(~i_input_mode_bits) & (o_pin_oe | o_pullup_en | o_rx_en))
      == 16'h0000)
      else $error("analog pin left active");
   a_pp_no_pull: assert property (@(posedge i_mclk) disable iff (i_rst)
      ($past(i_output_mode_bits) & o_pullup_en) == 16'h0000)
      else $error("pullup on push-pull pin");
   a_pull_od: assert property (@(posedge i_mclk) disable iff (i_rst)
      ##1 !$past(i_pullup_disable) && !$past(i_xbar_enable) |->
      o_pullup_en == ($past(i_input_mode_bits) & ~$past(i_output_mode_bits)))
      else $error("open-drain pullup missing");
   a_uart_fixed: assert property (@(posedge i_mclk) disable iff (i_rst)
      $past(i_xbar_enable) && $past(i_periph_select_lo[SEL_UART]) |->
      o_pin_assigned[tx_pin] && o_pin_assigned[rx_pin])
      else $error("uart pins not fixed");
   a_nss_3wire: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_slave_select_mode == NSS_3WIRE |-> !want[F_NSS])
      else $error("slave select taken in 3-wire mode");
   a_read_pin: assert property (@(posedge i_mclk) disable iff (i_rst)
      ##1 $past(i_input_mode_bits) == 16'hffff |-> o_port_read == $past(pin_s))
      else $error("port read differs from pin");
   c_enable: cover property (@(posedge i_mclk) $rose(i_xbar_enable));
   c_uart_on: cover property (@(posedge i_mclk) o_pin_assigned[tx_pin]);
   c_all_pins: cover property (@(posedge i_mclk) &o_pin_assigned);
endmodule

// file: hw/xbar_pkg.sv
// Purpose: constants for the priority pin crossbar
// Assumes: 16 port pins, two byte-wide ports, one system clock
// Notes: peripheral selection bit positions follow the selection registers
// Notes on behaviour
// - uart ranks highest, others descend below
// - selected function takes lowest free pin
// - assigned pins are passed over afterwards
// - skip-bit pins treated as already assigned
// - two-wire bus and uart take pin pairs
// - uart pins fixed for bootloading
// - leftover pins remain plain port io
// - slave select pin only in 4-wire mode
// - analog pin: no pullup, driver, receiver
// - input mode bit 1 digital, 0 analog
// - reset leaves every pin digital input
// - output mode bit alone picks driver
// - open-drain pins get pullup unless disabled
// - pullup disable ignores push-pull pins
// - pullup off while pin drives low
// - crossbar enable activates selected mapping
// - disabled crossbar keeps pins plain inputs
// - disabled crossbar turns all drivers off
// - port read returns actual pin levels
// - skip bit 1 excludes, 0 includes
// - timer array select routes 0..3 outputs
package xbar_pkg;
   localparam int NPINS = 16;
   localparam int NFUNC = 16;
   // selection register low byte fields
   localparam int SEL_UART = 0;
   localparam int SEL_SPI = 1;
   localparam int SEL_LIN = 2;
   localparam int SEL_SYSCK = 3;
   localparam int SEL_CMP = 4;
   localparam int SEL_CMPA = 5;
   // selection register high byte fields
   localparam int SEL_PCA_LO = 0;
   localparam int SEL_ECI = 3;
   localparam int SEL_T0 = 4;
   localparam int SEL_T1 = 5;
   // function slot numbers in descending priority
   localparam logic [3:0] F_TX = 4'h0;
   localparam logic [3:0] F_RX = 4'h1;
   localparam logic [3:0] F_SCK = 4'h2;
   localparam logic [3:0] F_MISO = 4'h3;
   localparam logic [3:0] F_MOSI = 4'h4;
   localparam logic [3:0] F_NSS = 4'h5;
   localparam logic [3:0] F_LIN_TX = 4'h6;
   localparam logic [3:0] F_LIN_RX = 4'h7;
   localparam logic [3:0] F_SYSCK = 4'h8;
   localparam logic [3:0] F_CMP = 4'h9;
   localparam logic [3:0] F_CMPA = 4'ha;
   localparam logic [3:0] F_CEX0 = 4'hb;
   localparam logic [3:0] F_CEX1 = 4'hc;
   localparam logic [3:0] F_CEX2 = 4'hd;
   localparam logic [3:0] F_ECI = 4'he;
   localparam logic [3:0] F_T0 = 4'hf;
   // fixed uart pins for the two variants
   localparam logic [3:0] UART_TX_PIN_A = 4'h4;
   localparam logic [3:0] UART_RX_PIN_A = 4'h5;
   localparam logic [3:0] UART_TX_PIN_B = 4'h3;
   localparam logic [3:0] UART_RX_PIN_B = 4'h4;
   // slave select mode codes; 2'b00 is 3-wire
   localparam logic [1:0] NSS_3WIRE = 2'h0;
   // reset values
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [15:0] INMODE_RST = 16'hffff;
   localparam logic [15:0] OUTMODE_RST = 16'h0000;
   localparam logic [15:0] SKIP_RST = 16'h0000;
   localparam logic [15:0] LATCH_RST = 16'hffff;
   localparam logic [4:0] NOFUNC = 5'h1f;
endpackage

// file: hw/pin_sync.sv
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs are asynchronous to i_mclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;
endmodule

// file: bench/pin_world.sv
// Purpose: external circuits hanging on the sixteen port pins
// Assumes: wired-and between device drivers and external drivers
// Notes: an undriven pin without pullup toggles, never holds a level
`timescale 1ns/1ps
module pin_world (
   // clock
   input wire logic i_mclk,
   // device side
   input wire logic [15:0] i_pin_drv,
   input wire logic [15:0] i_pin_oe,
   input wire logic [15:0] i_pullup_en,
   // external drivers
   input wire logic [15:0] i_ext_oe,
   input wire logic [15:0] i_ext_val,
   // resolved level
   output logic [15:0] o_level
);
   logic [15:0] float_r = 16'h5555;
   logic [15:0] low_t;
   logic [15:0] high_t;
   // floating pins must not read as a stable value
   always_ff @(posedge i_mclk) begin
      float_r <= ~float_r;
   end
   always_comb begin
      low_t = (i_pin_oe & ~i_pin_drv) | (i_ext_oe & ~i_ext_val);
      high_t = (i_pin_oe & i_pin_drv) | (i_ext_oe & i_ext_val);
      o_level = ~low_t & (high_t | i_pullup_en | float_r);
   end
endmodule

// file: bench/priority_pin_crossbar_bench.sv
// Purpose: self-checking bench for the priority pin crossbar
// Assumes: default uart variant, pins 4 and 5
// Notes: fixed waits follow the one and three cycle latencies
`timescale 1ns/1ps
module priority_pin_crossbar_bench;
   import xbar_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] sel_lo = 8'h00, sel_hi = 8'h00, sk0 = 8'h00, sk1 = 8'h00;
   logic xen = 1'b0, pud = 1'b0;
   logic [1:0] ssm = 2'h0;
   logic [15:0] inm = INMODE_RST, outm = OUTMODE_RST, latch = LATCH_RST;
   logic [15:0] fout = 16'h0000, ext_oe = 16'h0000, ext_val = 16'h0000;
   logic [15:0] lvl, drv, oe, pull_en, rx_en, port_rd, func_in, assigned;
   int error_cnt = 0;
   int total_checks = 0;
   always #25 i_mclk = ~i_mclk;
   priority_pin_crossbar u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_periph_select_lo(sel_lo), .i_periph_select_hi(sel_hi),
      .i_xbar_enable(xen), .i_pullup_disable(pud),
      .i_port0_skip_bits(sk0), .i_port1_skip_bits(sk1),
      .i_input_mode_bits(inm), .i_output_mode_bits(outm),
      .i_slave_select_mode(ssm), .i_port_latch(latch), .i_func_out(fout),
      .i_pin(lvl), .o_pin(drv), .o_pin_oe(oe), .o_pullup_en(pull_en),
      .o_rx_en(rx_en), .o_port_read(port_rd), .o_func_in(func_in),
      .o_pin_assigned(assigned));
   pin_world u_world (.i_mclk(i_mclk), .i_pin_drv(drv), .i_pin_oe(oe),
      .i_pullup_en(pull_en), .i_ext_oe(ext_oe), .i_ext_val(ext_val),
      .o_level(lvl));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #5;
   endtask
   // one setting per cycle: modes, skips, selects, then enable
   task automatic cfg(input logic [15:0] im, om, input logic [7:0] s0, s1,
         lo, hi, input logic [1:0] sm, input logic en);
      step(1);
      inm = im;
      step(1);
      outm = om;
      step(1);
      sk0 = s0;
      sk1 = s1;
      step(1);
      ssm = sm;
      sel_lo = lo;
      sel_hi = hi;
      step(1);
      xen = en;
      step(2);
   endtask
   task automatic map(input logic [7:0] lo, hi, s0, s1,
         input logic [1:0] sm, input logic [15:0] exp);
      cfg(16'hffff, 16'h0000, s0, s1, lo, hi, sm, 1'b1);
      chk(assigned, exp);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      step(3);
      chk(oe, 16'h0000);
      chk(rx_en, 16'hffff);
      chk(assigned, 16'h0000);
      step(2);
      i_rst = 1'b0;
      cfg(16'hffff, 16'hffff, 8'h00, 8'h00, 8'h3f, 8'h3b, 2'h1, 1'b0);
      chk(assigned, 16'h0000);
      chk(oe, 16'h0000);
      map(8'h3f, 8'h3b, 8'h00, 8'h00, 2'h1, 16'hffff);
      map(8'h01, 8'h00, 8'h00, 8'h00, 2'h0, 16'h0030);
      map(8'h03, 8'h00, 8'h00, 8'h00, 2'h0, 16'h0037);
      map(8'h03, 8'h00, 8'h00, 8'h00, 2'h1, 16'h003f);
      map(8'h03, 8'h00, 8'h33, 8'h00, 2'h0, 16'h007c);
      map(8'h02, 8'h00, 8'hff, 8'h01, 2'h0, 16'h0e00);
      map(8'h04, 8'h00, 8'h00, 8'h00, 2'h0, 16'h0003);
      map(8'h08, 8'h08, 8'h00, 8'h00, 2'h0, 16'h0003);
      map(8'h30, 8'h30, 8'h00, 8'h00, 2'h0, 16'h0007);
      for (int n = 0; n < 4; n++) begin
         map(8'h00, 8'(n), 8'h00, 8'h00, 2'h0, 16'((1 << n) - 1));
      end
      latch = 16'h0f0f;
      ext_oe = 16'h0200;
      cfg(16'hffff, 16'h00ff, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
      step(4);
      chk(oe, 16'hf0ff);
      chk(drv & oe, 16'h000f);
      chk(pull_en & 16'hff00, 16'h0f00);
      chk(port_rd, 16'h0d0f);
      pud = 1'b1;
      step(2);
      chk(pull_en & 16'hff00, 16'h0000);
      pud = 1'b0;
      ext_oe = 16'h0000;
      latch = 16'hffff;
      cfg(16'hfffe, 16'h0000, 8'h01, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
      step(4);
      chk(rx_en, 16'hfffe);
      chk(pull_en, 16'hfffe);
      chk(port_rd, 16'hfffe);
      latch = 16'h0000;
      step(2);
      chk(oe, 16'hfffe);
      chk(pull_en, 16'h0000);
      fout = 16'h0101;
      latch = 16'hffff;
      cfg(16'hffff, 16'hffff, 8'h00, 8'h00, 8'h09, 8'h01, 2'h0, 1'b1);
      chk(drv & 16'h0013, 16'h0011);
      chk(oe & 16'h0013, 16'h0013);
      outm = 16'h0000;
      step(2);
      chk(oe & 16'h0013, 16'h0002);
      fout = 16'hffff;
      ext_oe = 16'h0020;
      cfg(16'hffff, 16'h0000, 8'h00, 8'h00, 8'h01, 8'h00, 2'h0, 1'b1);
      step(4);
      chk(port_rd & 16'h0020, 16'h0000);
      chk({15'h0000, func_in[F_RX]}, 16'h0000);
      ext_val = 16'h0020;
      step(4);
      chk(port_rd & 16'h0020, 16'h0020);
      chk({15'h0000, func_in[F_RX]}, 16'h0001);
      close_out();
   end
endmodule
